// [design/ait_defines.vh]
// Constants for the converter injection timer: map, fields, resets, timing
`ifndef AIT_DEFINES_VH
`define AIT_DEFINES_VH

// ----------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------
`define AIT_ADDR_W        16
`define AIT_DATA_W        16

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define AIT_OFS_CTRL      16'hC000
`define AIT_OFS_START     16'hC002
`define AIT_OFS_END       16'hC004
`define AIT_OFS_CUR       16'hC006
`define AIT_OFS_STAT      16'hC008
`define AIT_OFS_CLR       16'hC00A
`define AIT_OFS_IEN       16'hC00C

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define AIT_RST_CTRL      16'h0000
`define AIT_RST_START     16'h0000
`define AIT_RST_END       16'h0000
`define AIT_RST_CUR       16'h0000
`define AIT_RST_IRQ       2'h0

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define AIT_CTL_RUN       0
`define AIT_CTL_DOWN      1
`define AIT_CTL_ACT_LO    2
`define AIT_CTL_ACT_HI    3
`define AIT_CTL_INJ       4
`define AIT_CTL_PSC_LO    5
`define AIT_CTL_PSC_HI    9
`define AIT_CTL_MASK      16'h03FF

// End-of-period actions
`define AIT_ACT_RELOAD    2'h0
`define AIT_ACT_STOP      2'h1
`define AIT_ACT_CONT      2'h2

// ----------------------------------------------------------------------
// Status and interrupt fields
// ----------------------------------------------------------------------
`define AIT_IRQ_W         2
`define AIT_IRQ_END       0
`define AIT_IRQ_HALT      1
`define AIT_STAT_ST_LO    8
`define AIT_STAT_ST_HI    9

// ----------------------------------------------------------------------
// Prescaler and timing
// ----------------------------------------------------------------------
`define AIT_PSC_W         33
`define AIT_PSC_SEL_W     5
`define AIT_PSC_EXP_MIN   6'h02
`define AIT_INJ_CYC       2'h2

`endif

// [design/ait_prescaler.v]
// Bus clock divider producing the counting tick of the injection timer
`include "ait_defines.vh"

module ait_prescaler (
	// Clock and reset
	input  wire                         clk,
	input  wire                         rst_n,
	// Control
	input  wire                         run,
	input  wire [`AIT_PSC_SEL_W-1:0]    sel,
	// Counting tick, one cycle every 2^(sel+2) cycles while running
	output wire                         tick
);

	reg  [`AIT_PSC_W-1:0] div_q;
	wire [`AIT_PSC_W-1:0] div_d;
	wire [`AIT_PSC_W-1:0] mask;

	// ------------------------------------------------------------------
	// Period mask
	// ------------------------------------------------------------------
	function [`AIT_PSC_W-1:0] ait_mask;
		input [`AIT_PSC_SEL_W-1:0] s;
		reg   [`AIT_PSC_W:0]       one;
		begin
			one = {{`AIT_PSC_W{1'b0}}, 1'b1} << ({1'b0, s} + `AIT_PSC_EXP_MIN);
			ait_mask = one[`AIT_PSC_W-1:0] - {{(`AIT_PSC_W-1){1'b0}}, 1'b1};
		end
	endfunction

	assign mask = ait_mask(sel);
	// Cleared while stopped so the first tick lands a full period later
	assign div_d = run ? (div_q + {{(`AIT_PSC_W-1){1'b0}}, 1'b1})
	                   : {`AIT_PSC_W{1'b0}};
	assign tick  = run && ((div_q & mask) == mask);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= {`AIT_PSC_W{1'b0}};
		end else begin
			div_q <= div_d;
		end
	end

endmodule

// [design/ait_timer.v]
// Converter injection timer: registers, counter, compare and inject pulse
//
// Summary of operation
// - Current value advances only on prescaler ticks, not on every clock.
// - Prescaler divides the bus clock by 2^2 up to 2^33.
// - Counter source is start value, incrementer or decrementer per control.
// - First tick after run enable loads the start value into the counter.
// - Counter is compared with the end value; equality ends the period.
// - At period end: reload start value, stop, or keep counting.
// - Injection pulse is issued at period end only if enabled.
// - Pulse comes from the rising edge of equality, two cycles long.
//
// Design decision made here: strobed register access.
`include "ait_defines.vh"

module ait_timer (
	// Clock and reset
	input  wire                     ref_clk,
	input  wire                     nrst,
	// Register port
	input  wire [`AIT_ADDR_W-1:0]   reg_addr,
	input  wire [`AIT_DATA_W-1:0]   reg_wdata,
	input  wire                     reg_wr,
	input  wire                     reg_rd,
	output wire [`AIT_DATA_W-1:0]   reg_rdata,
	// Converter trigger and interrupt
	output wire                     conversion_inject_pulse,
	output wire                     irq
);

	// ------------------------------------------------------------------
	// States of the counting sequence
	// ------------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ARM  = 2'h1;
	localparam [1:0] ST_RUN  = 2'h2;
	localparam [1:0] ST_HALT = 2'h3;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	reg                     rst_meta_q;
	reg                     rst_sync_q;
	wire                    rst_n;

	reg  [`AIT_DATA_W-1:0]  count_control_q;
	reg  [`AIT_DATA_W-1:0]  count_start_value_q;
	reg  [`AIT_DATA_W-1:0]  count_end_value_q;
	reg  [`AIT_DATA_W-1:0]  count_current_value_q;
	reg  [`AIT_DATA_W-1:0]  count_current_value_d;
	reg  [1:0]              state_q;
	reg  [1:0]              state_d;
	reg                     eq_q;
	reg  [1:0]              inj_cnt_q;
	reg  [1:0]              inj_cnt_d;
	reg                     inj_q;
	reg  [`AIT_IRQ_W-1:0]   stat_q;
	reg  [`AIT_IRQ_W-1:0]   ien_q;
	reg                     irq_q;
	reg  [`AIT_DATA_W-1:0]  rd_mux;
	reg  [`AIT_DATA_W-1:0]  rdata_q;

	wire                    run_enable;
	wire                    count_down;
	wire [1:0]              end_action;
	wire                    inject_enable;
	wire [`AIT_PSC_SEL_W-1:0] psc_sel;
	wire                    psc_run;
	wire                    tick;
	wire                    match;
	wire                    eq_rise;
	wire [`AIT_DATA_W-1:0]  step_value;
	wire [`AIT_IRQ_W-1:0]   events;
	wire [`AIT_IRQ_W-1:0]   clr_mask;
	wire [`AIT_IRQ_W-1:0]   stat_d;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function ait_hit;
		input [`AIT_ADDR_W-1:0] addr;
		input [`AIT_ADDR_W-1:0] ofs;
		begin
			ait_hit = (addr == ofs);
		end
	endfunction

	// ------------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------------
	// Assertion is immediate, release is two clocks late and glitch free
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign rst_n = rst_sync_q;

	// ------------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------------
	assign run_enable    = count_control_q[`AIT_CTL_RUN];
	assign count_down    = count_control_q[`AIT_CTL_DOWN];
	assign end_action    = count_control_q[`AIT_CTL_ACT_HI:`AIT_CTL_ACT_LO];
	assign inject_enable = count_control_q[`AIT_CTL_INJ];
	assign psc_sel       = count_control_q[`AIT_CTL_PSC_HI:`AIT_CTL_PSC_LO];

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	// Written at any time; changing anything but run enable while counting
	// is left to software discipline, so no interlock is spent on it.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_control_q     <= `AIT_RST_CTRL;
			count_start_value_q <= `AIT_RST_START;
			count_end_value_q   <= `AIT_RST_END;
			ien_q               <= `AIT_RST_IRQ;
		end else if (reg_wr) begin
			if (ait_hit(reg_addr, `AIT_OFS_CTRL)) begin
				count_control_q <= reg_wdata & `AIT_CTL_MASK;
			end
			if (ait_hit(reg_addr, `AIT_OFS_START)) begin
				count_start_value_q <= reg_wdata;
			end
			if (ait_hit(reg_addr, `AIT_OFS_END)) begin
				count_end_value_q <= reg_wdata;
			end
			if (ait_hit(reg_addr, `AIT_OFS_IEN)) begin
				ien_q <= reg_wdata[`AIT_IRQ_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	assign psc_run = run_enable && (state_q != ST_HALT);

	ait_prescaler u_prescaler (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.run   (psc_run),
		.sel   (psc_sel),
		.tick  (tick)
	);

	// ------------------------------------------------------------------
	// Compare and step
	// ------------------------------------------------------------------
	// Only a loaded counter is compared, so a stale value never matches
	assign match = (state_q == ST_RUN) &&
	               (count_current_value_q == count_end_value_q);

	assign step_value = count_down ?
		(count_current_value_q - {{(`AIT_DATA_W-1){1'b0}}, 1'b1}) :
		(count_current_value_q + {{(`AIT_DATA_W-1){1'b0}}, 1'b1});

	// ------------------------------------------------------------------
	// Counting sequence
	// ------------------------------------------------------------------
	always @* begin
		state_d               = state_q;
		count_current_value_d = count_current_value_q;
		case (state_q)
			ST_IDLE: begin
				if (run_enable) begin
					state_d = ST_ARM;
				end
			end
			ST_ARM: begin
				if (!run_enable) begin
					state_d = ST_IDLE;
				end else if (tick) begin
					count_current_value_d = count_start_value_q;
					state_d               = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!run_enable) begin
					state_d = ST_IDLE;
				end else if (tick) begin
					if (match) begin
						case (end_action)
							`AIT_ACT_RELOAD: begin
								count_current_value_d = count_start_value_q;
							end
							`AIT_ACT_STOP: begin
								state_d = ST_HALT;
							end
							default: begin
								count_current_value_d = step_value;
							end
						endcase
					end else begin
						count_current_value_d = step_value;
					end
				end
			end
			ST_HALT: begin
				if (!run_enable) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// The counter keeps its last value when stopped so software can read it
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q               <= ST_IDLE;
			count_current_value_q <= `AIT_RST_CUR;
		end else begin
			state_q               <= state_d;
			count_current_value_q <= count_current_value_d;
		end
	end

	// ------------------------------------------------------------------
	// Injection pulse
	// ------------------------------------------------------------------
	assign eq_rise = match && !eq_q;

	always @* begin
		inj_cnt_d = inj_cnt_q;
		if (eq_rise && inject_enable) begin
			inj_cnt_d = `AIT_INJ_CYC;
		end else if (inj_cnt_q != 2'h0) begin
			inj_cnt_d = inj_cnt_q - 2'h1;
		end
	end

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			eq_q      <= 1'b0;
			inj_cnt_q <= 2'h0;
			inj_q     <= 1'b0;
		end else begin
			eq_q      <= match;
			inj_cnt_q <= inj_cnt_d;
			inj_q     <= (inj_cnt_d != 2'h0);
		end
	end

	assign conversion_inject_pulse = inj_q;

	// ------------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------------
	assign events[`AIT_IRQ_END]  = eq_rise;
	assign events[`AIT_IRQ_HALT] = (state_q == ST_RUN) && (state_d == ST_HALT);

	assign clr_mask = (reg_wr && ait_hit(reg_addr, `AIT_OFS_CLR)) ?
	                  reg_wdata[`AIT_IRQ_W-1:0] : {`AIT_IRQ_W{1'b0}};

	// A new event in the cycle of its clear survives the clear
	assign stat_d = (stat_q & ~clr_mask) | events;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= `AIT_RST_IRQ;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q  <= |(stat_q & ien_q);
		end
	end

	assign irq = irq_q;

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	always @* begin
		rd_mux = {`AIT_DATA_W{1'b0}};
		case (reg_addr)
			`AIT_OFS_CTRL: begin
				rd_mux = count_control_q;
			end
			`AIT_OFS_START: begin
				rd_mux = count_start_value_q;
			end
			`AIT_OFS_END: begin
				rd_mux = count_end_value_q;
			end
			`AIT_OFS_CUR: begin
				rd_mux = count_current_value_q;
			end
			`AIT_OFS_STAT: begin
				rd_mux[`AIT_IRQ_W-1:0] = stat_q;
				rd_mux[`AIT_STAT_ST_HI:`AIT_STAT_ST_LO] = state_q;
			end
			`AIT_OFS_IEN: begin
				rd_mux[`AIT_IRQ_W-1:0] = ien_q;
			end
			default: begin
				rd_mux = {`AIT_DATA_W{1'b0}};
			end
		endcase
	end

	// Data is valid only in the cycle after the strobe, zero otherwise
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= {`AIT_DATA_W{1'b0}};
		end else if (reg_rd) begin
			rdata_q <= rd_mux;
		end else begin
			rdata_q <= {`AIT_DATA_W{1'b0}};
		end
	end

	assign reg_rdata = rdata_q;

endmodule

// [tb/ait_timer_assertions.sv]
// Port-level assertions for the converter injection timer
module ait_timer_chk (
	// Clock and reset
	input logic        ref_clk,
	input logic        nrst,
	// Register port
	input logic [15:0] reg_addr,
	input logic [15:0] reg_wdata,
	input logic        reg_wr,
	input logic        reg_rd,
	input logic [15:0] reg_rdata,
	// Trigger and interrupt
	input logic        conversion_inject_pulse,
	input logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	// ----
	// Write followed at once by a read of the same place
	// ----
	sequence wr_rd(a);
		reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
	endsequence
	property val_back(a);
		wr_rd(a) |=> reg_rdata == $past(reg_wdata, 2);
	endproperty

	inj_width_a: assert property (
		$rose(conversion_inject_pulse) |=>
		conversion_inject_pulse ##1 !conversion_inject_pulse)
		else $error("inject pulse is not two cycles long");
	// Ticks are at least four clocks apart, so edges cannot crowd
	inj_gap_a: assert property (
		$rose(conversion_inject_pulse) |=>
		(!$rose(conversion_inject_pulse))[*3])
		else $error("inject pulses closer than one tick");
	rd_idle_a: assert property (
		!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data outside the answer cycle");
	ctrl_back_a: assert property (
		wr_rd(16'hC000) |=> reg_rdata == ($past(reg_wdata, 2) & 16'h03FF))
		else $error("control readback wrong");
	ctrl_top_a: assert property (
		reg_rd && reg_addr == 16'hC000 |=> reg_rdata[15:10] == 6'h00)
		else $error("control upper bits not zero");
	start_back_a: assert property (val_back(16'hC002))
		else $error("start value readback wrong");
	end_back_a: assert property (val_back(16'hC004))
		else $error("end value readback wrong");
	clr_read_a: assert property (
		reg_rd && (reg_addr == 16'hC00A || reg_addr > 16'hC00C)
		|=> reg_rdata == 16'h0000)
		else $error("write-only or unmapped read not zero");
	rst_quiet_a: assert property (
		$rose(nrst) |-> (!conversion_inject_pulse && !irq)[*4])
		else $error("output active right after reset");
endmodule

// [tb/ait_adc_trigger.sv]
// Converter trigger input model: counts inject pulses, checks width
module ait_adc_trigger (
	// Clock and reset
	input  logic ref_clk,
	input  logic nrst,
	// Trigger from the timer
	input  logic conversion_inject_pulse,
	// Observations
	output int   n_pulse,
	output int   n_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	int width;

	// Each rising edge starts one conversion
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			n_pulse <= 0;
			n_bad   <= 0;
			width   <= 0;
		end else if (conversion_inject_pulse) begin
			width <= width + 1;
			if (width == 0)
				n_pulse <= n_pulse + 1;
		end else begin
			if (width != 0 && width != 2)
				n_bad <= n_bad + 1;
			width <= 0;
		end
	end
endmodule

// [tb/tb_adc_injection_timer.sv]
// Self-checking bench for the converter injection timer
module tb_adc_injection_timer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk;
	logic        nrst;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;
	logic        conversion_inject_pulse;
	logic        irq;
	logic [15:0] v;
	int          n_mismatch;
	int          num_checks;
	int          n_pulse;
	int          n_bad;
	int          n;
	int          p0;

	ait_timer u_dut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .conversion_inject_pulse, .irq);
	ait_adc_trigger u_adc (.ref_clk, .nrst, .conversion_inject_pulse,
		.n_pulse, .n_bad);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// ----
	// Bus tasks: a write leaves its strobe for the next call to drop
	// ----
	task automatic bus(input logic w, input logic r, input logic [15:0] a,
		input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr    <= w;
		reg_rd    <= r;
		reg_addr  <= a;
		reg_wdata <= d;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic idle(input int k);
		repeat (k) bus(1'b0, 1'b0, 16'h0000, 16'h0000);
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		bus(1'b0, 1'b1, a, 16'h0000);
		idle(1);
		#1 d = reg_rdata;
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk(d, e);
	endtask
	// Clocks from now until the next rising edge of the trigger
	task automatic wait_rise(output int k);
		k = 0;
		while (conversion_inject_pulse === 1'b1 && k < 300) begin
			idle(1);
			#1 k++;
		end
		while (conversion_inject_pulse !== 1'b1 && k < 300) begin
			idle(1);
			#1 k++;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		n_mismatch++;
		tally_and_finish;
	end

	// ----
	// Tests
	// ----
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		n_mismatch = 0;
		num_checks = 0;
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		idle(4);
		for (int i = 0; i < 4; i++)
			rdchk(16'hC000 + 16'(2 * i), 16'h0000);
		wr(16'hC006, 16'h1234);
		rdchk(16'hC006, 16'h0000);
		rdchk(16'hC010, 16'h0000);
		wr(16'hC000, 16'hFFFE);
		rdchk(16'hC000, 16'h03FE);
		wr(16'hC002, 16'h0000);
		rdchk(16'hC002, 16'h0000);
		wr(16'hC004, 16'h0002);
		rdchk(16'hC004, 16'h0002);
		// Up, reload, inject, tick every 4 clocks: 3 ticks per period
		wr(16'hC00C, 16'h0001);
		rdchk(16'hC00C, 16'h0001);
		wr(16'hC000, 16'h0010);
		p0 = n_pulse;
		wr(16'hC000, 16'h0011);
		wait_rise(n);
		chk(16'(n), 16'h000E);
		wait_rise(n);
		chk(16'(n), 16'h000C);
		chk({15'h0000, irq}, 16'h0001);
		wr(16'hC000, 16'h0010);
		rd(16'hC008, v);
		chk(v & 16'h0001, 16'h0001);
		chk(16'(n_pulse - p0), 16'h0002);
		wr(16'hC00A, 16'h0003);
		idle(3);
		#1 chk({15'h0000, irq}, 16'h0000);
		// Down, stop at end, inject off, interrupt masked
		wr(16'hC002, 16'h0005);
		wr(16'hC004, 16'h0003);
		wr(16'hC00C, 16'h0000);
		wr(16'hC000, 16'h0006);
		p0 = n_pulse;
		wr(16'hC000, 16'h0007);
		idle(40);
		rdchk(16'hC006, 16'h0003);
		chk(16'(n_pulse - p0), 16'h0000);
		rd(16'hC008, v);
		chk(v & 16'h0302, 16'h0302);
		chk({15'h0000, irq}, 16'h0000);
		wr(16'hC00C, 16'h0002);
		idle(3);
		#1 chk({15'h0000, irq}, 16'h0001);
		wr(16'hC000, 16'h0006);
		wr(16'hC00A, 16'h0003);
		// Up, continue, inject, tick every 8 clocks
		wr(16'hC002, 16'h0000);
		wr(16'hC004, 16'h0001);
		wr(16'hC000, 16'h0038);
		wr(16'hC000, 16'h0039);
		wait_rise(n);
		chk(16'(n), 16'h0012);
		idle(40);
		rd(16'hC006, v);
		chk({15'h0000, v > 16'h0001}, 16'h0001);
		wr(16'hC000, 16'h0038);
		idle(2);
		chk(16'(n_bad), 16'h0000);
		rd(16'hC008, v);
		chk(v & 16'h0300, 16'h0000);
		tally_and_finish;
	end
endmodule

bind ait_timer ait_timer_chk u_chk (.ref_clk, .nrst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .conversion_inject_pulse, .irq);
